// >>> core/arp_regs.svh
// Purpose: Register indices, field positions and reset values of the auto-reload PWM timer
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef ARP_REGS_SVH
`define ARP_REGS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ARP_IDX_DUTY3 8'h73
`define ARP_IDX_DUTY2 8'h74
`define ARP_IDX_DUTY1 8'h75
`define ARP_IDX_DUTY0 8'h76
`define ARP_IDX_PWM_ENABLE_POLARITY 8'h77
`define ARP_IDX_CSR 8'h78
`define ARP_IDX_CAR 8'h79
`define ARP_IDX_ARR 8'h7a
`define ARP_IDX_ICCSR 8'h7b
`define ARP_IDX_ICR1 8'h7c
`define ARP_IDX_ICR2 8'h7d
`define ARP_IDX_IRQ_STATUS 8'h7e
`define ARP_IDX_IRQ_CLEAR 8'h7f
`define ARP_IDX_IRQ_ENABLE 8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ARP_PWM_ENABLE_POLARITY_OE_LSB 4
`define ARP_CSR_EXCL 7
`define ARP_CSR_CC_LSB 4
`define ARP_CSR_TCE 3
`define ARP_CSR_FCRL 2
`define ARP_CSR_OIE 1
`define ARP_CSR_OVF 0
`define ARP_ICCSR_CS_LSB 4
`define ARP_ICCSR_CIE_LSB 2
`define ARP_ICCSR_CF_LSB 0
`define ARP_IRQ_OVF 0
`define ARP_IRQ_CAP1 1
`define ARP_IRQ_CAP2 2

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define ARP_RST_BYTE 8'h00
`define ARP_RST_IRQ 3'h0
`define ARP_CNT_MAX 8'hff
`define ARP_RESP_OKAY 2'h0
`define ARP_RESP_SLVERR 2'h2

`endif

// >>> core/arp_pkg.sv
// Purpose: Shared types of the auto-reload PWM timer
// Assumes: Constants live in arp_regs.svh
// Notes:   Types only
package arp_pkg;

    // ----------------------------------------------------------------
    // Pin groups and capture result
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe;
    } arp_pwm_pins_t;

    typedef struct packed {
        logic evt;
        logic [7:0] value;
    } arp_cap_t;

endpackage : arp_pkg

// >>> core/arp_capture.sv
// Purpose: One input capture channel: pin synchroniser, edge select, count latch
// Assumes: Pin is asynchronous to aclk
// Notes:   Event and value appear together, three cycles after the pin edge
`timescale 1ns/1ps
module arp_capture (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic cap_pin, // Capture pin, asynchronous
    input wire logic rising_sel, // 1 rising edge, 0 falling edge
    input wire logic [7:0] count, // Live counter value
    output arp_pkg::arp_cap_t result // Event pulse and held value
);
    import arp_pkg::*;

    logic sync1;
    logic sync2;
    logic sync3;
    wire edge_seen = rising_sel ? (sync2 & ~sync3) : (~sync2 & sync3);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            result <= '0;
        end else begin
            sync1 <= cap_pin;
            sync2 <= sync1;
            sync3 <= sync2;
            result.evt <= edge_seen;
            if (edge_seen) begin
                result.value <= count;
            end
        end
    end

endmodule : arp_capture

// >>> core/arp_timer.sv
// Purpose: 8-bit auto-reload timer with four PWM outputs and two input captures, AXI4-Lite slave
// Assumes: All pins asynchronous to aclk; one write and one read under way at a time
// Notes:   Summary of operation below
// Summary of operation
// - Bits 7:4 of PWM control enable each channel's output pin.
// - Changing a polarity bit inverts that output at once, not at overflow.
// - Each channel has an 8-bit read/write duty value feeding its compare.
// - All channels share the first edge, set by the reload value.
// - Capture control bits 5:4 pick falling (0) or rising (1) edge.
// - Capture sets flag bits 1:0; reading that capture value clears it.
// - Capture control bits 7:6 always read zero.
// - Capture value registers are read-only, holding the latched counter.
// - At overflow the counter reloads and outputs switch per polarity.
// - Overflow flag sets on max to reload; cleared by reading control/status.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "arp_regs.svh"
module arp_timer (
    input wire logic aclk, // System clock, 125 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic ext_clk_pin, // External counter clock pin
    input wire logic [1:0] cap_pins, // Capture pins, bit 0 channel 1
    output arp_pkg::arp_pwm_pins_t pwm_pins, // PWM levels and output enables
    output logic irq // Level interrupt
);
    import arp_pkg::*;

    // ----------------------------------------------------------------
    // Decode helper
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[9:2] == idx) && (addr[11:10] == 2'h0);
    endfunction : hit

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [3:0][7:0] duty;
    logic [3:0][7:0] compare;
    logic [7:0] pwm_enable_polarity;
    logic excl;
    logic [2:0] cc;
    logic tce;
    logic oie;
    logic ovf;
    logic [7:0] cnt;
    logic [7:0] reload;
    logic [6:0] presc;
    logic [1:0] cs;
    logic [1:0] cie;
    logic [1:0] cf;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    arp_cap_t cap [2];

    logic aw_got;
    logic w_got;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got & ~s_axi_bvalid;
    wire wr_go = aw_got & w_got;
    wire wr_en = wr_go & wstrb_q[0];
    wire [7:0] wbyte = wdata_q[7:0];
    wire wr_duty3 = wr_en & hit(awaddr_q, `ARP_IDX_DUTY3);
    wire wr_duty2 = wr_en & hit(awaddr_q, `ARP_IDX_DUTY2);
    wire wr_duty1 = wr_en & hit(awaddr_q, `ARP_IDX_DUTY1);
    wire wr_duty0 = wr_en & hit(awaddr_q, `ARP_IDX_DUTY0);
    wire wr_pwm_enable_polarity = wr_en & hit(awaddr_q, `ARP_IDX_PWM_ENABLE_POLARITY);
    wire wr_csr = wr_en & hit(awaddr_q, `ARP_IDX_CSR);
    wire wr_car = wr_en & hit(awaddr_q, `ARP_IDX_CAR);
    wire wr_arr = wr_en & hit(awaddr_q, `ARP_IDX_ARR);
    wire wr_iccsr = wr_en & hit(awaddr_q, `ARP_IDX_ICCSR);
    wire wr_iclr = wr_en & hit(awaddr_q, `ARP_IDX_IRQ_CLEAR);
    wire wr_ien = wr_en & hit(awaddr_q, `ARP_IDX_IRQ_ENABLE);
    wire wr_mapped = hit(awaddr_q, `ARP_IDX_DUTY3) | hit(awaddr_q, `ARP_IDX_DUTY2) |
        hit(awaddr_q, `ARP_IDX_DUTY1) | hit(awaddr_q, `ARP_IDX_DUTY0) |
        hit(awaddr_q, `ARP_IDX_PWM_ENABLE_POLARITY) | hit(awaddr_q, `ARP_IDX_CSR) |
        hit(awaddr_q, `ARP_IDX_CAR) | hit(awaddr_q, `ARP_IDX_ARR) |
        hit(awaddr_q, `ARP_IDX_ICCSR) | hit(awaddr_q, `ARP_IDX_IRQ_CLEAR) |
        hit(awaddr_q, `ARP_IDX_IRQ_ENABLE) | hit(awaddr_q, `ARP_IDX_ICR1) |
        hit(awaddr_q, `ARP_IDX_ICR2) | hit(awaddr_q, `ARP_IDX_IRQ_STATUS);
    // Force-reload bit is a strobe and never stored
    wire force_reload = wr_csr & wbyte[`ARP_CSR_FCRL];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `ARP_RESP_OKAY : `ARP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire rd_csr = rd_go & hit(s_axi_araddr, `ARP_IDX_CSR);
    wire rd_icr1 = rd_go & hit(s_axi_araddr, `ARP_IDX_ICR1);
    wire rd_icr2 = rd_go & hit(s_axi_araddr, `ARP_IDX_ICR2);
    wire [7:0] csr_view = {excl, cc, tce, 1'b0, oie, ovf};
    wire [7:0] iccsr_view = {2'b00, cs, cie, cf};
    wire [7:0] idx_r = s_axi_araddr[9:2];
    wire rd_aligned = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[11:10] == 2'h0);
    wire rd_mapped = rd_aligned && (idx_r >= `ARP_IDX_DUTY3) && (idx_r <= `ARP_IDX_IRQ_ENABLE);
    // Clear register reads as zero, it holds nothing
    wire [7:0] rd_byte =
        (idx_r == `ARP_IDX_DUTY3) ? duty[3] :
        (idx_r == `ARP_IDX_DUTY2) ? duty[2] :
        (idx_r == `ARP_IDX_DUTY1) ? duty[1] :
        (idx_r == `ARP_IDX_DUTY0) ? duty[0] :
        (idx_r == `ARP_IDX_PWM_ENABLE_POLARITY) ? pwm_enable_polarity :
        (idx_r == `ARP_IDX_CSR) ? csr_view :
        (idx_r == `ARP_IDX_CAR) ? cnt :
        (idx_r == `ARP_IDX_ARR) ? reload :
        (idx_r == `ARP_IDX_ICCSR) ? iccsr_view :
        (idx_r == `ARP_IDX_ICR1) ? cap[0].value :
        (idx_r == `ARP_IDX_ICR2) ? cap[1].value :
        (idx_r == `ARP_IDX_IRQ_STATUS) ? {5'h00, irq_status} :
        (idx_r == `ARP_IDX_IRQ_ENABLE) ? {5'h00, irq_enable} : `ARP_RST_BYTE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ARP_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_mapped ? rd_byte : `ARP_RST_BYTE};
            s_axi_rresp <= rd_mapped ? `ARP_RESP_OKAY : `ARP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler and counter
    // ----------------------------------------------------------------
    wire ext_rise = ext_s2 & ~ext_s3;
    wire in_tick = tce & (excl ? ext_rise : 1'b1);
    wire [6:0] presc_mask = 7'((8'h01 << cc) - 8'h01);
    wire cnt_tick = in_tick & ((presc & presc_mask) == presc_mask);
    wire ovf_evt = cnt_tick & (cnt == `ARP_CNT_MAX) & ~force_reload & ~wr_car;
    wire [7:0] next_cnt = (force_reload | ovf_evt) ? reload :
        wr_car ? wbyte : cnt_tick ? 8'(cnt + 8'h01) : cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            presc <= 7'h00;
            cnt <= `ARP_RST_BYTE;
        end else begin
            ext_s1 <= ext_clk_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            presc <= force_reload ? 7'h00 : (in_tick ? 7'(presc + 7'h01) : presc);
            cnt <= next_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Software registers and flags
    // ----------------------------------------------------------------
    wire [2:0] irq_set = {cap[1].evt, cap[0].evt, ovf_evt};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty <= '0;
            pwm_enable_polarity <= `ARP_RST_BYTE;
            {excl, cc, tce, oie} <= 6'h00;
            ovf <= 1'b0;
            reload <= `ARP_RST_BYTE;
            {cs, cie} <= 4'h0;
            cf <= 2'b00;
            irq_status <= `ARP_RST_IRQ;
            irq_enable <= `ARP_RST_IRQ;
        end else begin
            if (wr_duty3) duty[3] <= wbyte;
            if (wr_duty2) duty[2] <= wbyte;
            if (wr_duty1) duty[1] <= wbyte;
            if (wr_duty0) duty[0] <= wbyte;
            if (wr_pwm_enable_polarity) pwm_enable_polarity <= wbyte;
            if (wr_csr) begin
                {excl, cc, tce} <= wbyte[7:3];
                oie <= wbyte[`ARP_CSR_OIE];
            end
            if (wr_arr) reload <= wbyte;
            if (wr_iccsr) begin
                cs <= wbyte[5:4];
                cie <= wbyte[3:2];
            end
            // A new event in the clearing cycle wins
            ovf <= ovf_evt | (ovf & ~rd_csr);
            cf[0] <= cap[0].evt | (cf[0] & ~rd_icr1);
            cf[1] <= cap[1].evt | (cf[1] & ~rd_icr2);
            irq_status <= irq_set | (irq_status & ~(wr_iclr ? wbyte[2:0] : 3'h0));
            if (wr_ien) irq_enable <= wbyte[2:0];
        end
    end

    assign irq = (|(irq_status & irq_enable)) | (|(cf & cie)) | (ovf & oie);

    // ----------------------------------------------------------------
    // Capture channels
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_cap
        arp_capture u_cap (
            .aclk(aclk),
            .aresetn(aresetn),
            .cap_pin(cap_pins[c]),
            .rising_sel(cs[c]),
            .count(cnt),
            .result(cap[c])
        );
    end

    // ----------------------------------------------------------------
    // PWM channels
    // ----------------------------------------------------------------
    // Compare takes the duty value only at reload so a period is never torn
    wire [3:0] pwm_raw;
    wire [3:0] pwm_oe = pwm_enable_polarity[`ARP_PWM_ENABLE_POLARITY_OE_LSB +: 4];
    for (genvar p = 0; p < 4; p++) begin : g_pwm
        assign pwm_raw[p] = (cnt <= compare[p]) ^ pwm_enable_polarity[p];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare <= '0;
            pwm_pins <= '0;
        end else begin
            if (ovf_evt | force_reload) compare <= duty;
            pwm_pins.level <= pwm_oe & pwm_raw;
            pwm_pins.oe <= pwm_oe;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_OE_GATES: assert property ((pwm_pins.level & ~pwm_pins.oe) == 4'h0)
        else $error("PWM level high on disabled channel");
    AST_LEVEL: assert property (##1 pwm_pins.level[0] ==
        ($past(pwm_enable_polarity[4]) & (($past(cnt) <= $past(compare[0])) ^ $past(pwm_enable_polarity[0]))))
        else $error("PWM level does not follow compare and polarity");
    AST_POL_NOW: assert property ($changed(pwm_enable_polarity[0]) && pwm_enable_polarity[4] && $stable(pwm_enable_polarity[4])
        && $stable(cnt) && $stable(compare[0]) |=> $changed(pwm_pins.level[0]))
        else $error("Polarity change did not invert output");
    AST_DUTY_WR: assert property (wr_duty2 |=> duty[2] == $past(wbyte))
        else $error("Duty write lost");
    AST_RELOAD: assert property (ovf_evt |=> cnt == $past(reload) && compare[3] == $past(duty[3]))
        else $error("Overflow did not reload counter and compare");
    AST_EDGE_SEL: assert property (rd_go && hit(s_axi_araddr, `ARP_IDX_ICCSR)
        |=> s_axi_rdata[5:4] == $past(cs))
        else $error("Edge select readback wrong");
    AST_CAP_FLAG: assert property (cap[0].evt |=> cf[0])
        else $error("Capture flag not set");
    AST_FLAG_CLR: assert property (rd_icr2 && !cap[1].evt |=> !cf[1])
        else $error("Capture flag not cleared by read");
    AST_RSVD: assert property (rd_go |=> s_axi_rdata[31:8] == 24'h000000
        && ($past(idx_r) != `ARP_IDX_ICCSR || s_axi_rdata[7:6] == 2'b00))
        else $error("Reserved bits not zero");
    AST_CAP_VAL: assert property (cap[1].evt |-> cap[1].value == $past(cnt))
        else $error("Capture value not the counter");
    AST_OVF_SET: assert property (ovf_evt |=> ovf ##1 1'b1)
        else $error("Overflow flag not set");
    AST_OVF_CLR: assert property (rd_csr && !ovf_evt |=> !ovf)
        else $error("Overflow flag not cleared by read");
    AST_CAP_IRQ: assert property ((cf[0] && cie[0]) |-> irq)
        else $error("Capture interrupt missing");
    AST_RD_ANS: assert property (rd_go |=> s_axi_rvalid [*1])
        else $error("Read not answered");

endmodule : arp_timer

// >>> testbench/arp_pin_model.sv
// Purpose: Pin-side partner of the PWM timer: capture sources and PWM level monitor
// Assumes: Capture pins idle low; external clock pin idle low, pulsed on request
// Notes:   Testbench calls set_cap and measure by hierarchical name
`timescale 1ns/1ps
module arp_pin_model (
    input wire logic aclk, // System clock
    input wire arp_pkg::arp_pwm_pins_t pwm_pins, // PWM levels and enables
    output logic [1:0] cap_pins, // Capture sources
    output logic ext_clk_pin // External count clock, idle low
);
    import arp_pkg::*;
    initial cap_pins = 2'h0;
    initial ext_clk_pin = 1'b0;

    // Edge launched just after a clock edge, asynchronous in spirit
    task automatic set_cap(input int ch, input logic lvl);
        @(posedge aclk);
        cap_pins[ch] <= lvl;
    endtask : set_cap

    // Slow pulses so the synchroniser sees every rising edge
    task automatic pulse_ext(input int n);
        repeat (n) begin
            @(posedge aclk);
            ext_clk_pin <= 1'b1;
            repeat (3) @(posedge aclk);
            ext_clk_pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
    endtask : pulse_ext

    // Sampled mid-cycle so registered outputs are settled
    task automatic measure(input int n, output int h, output int hd);
        h = 0;
        hd = 0;
        repeat (n) begin
            @(negedge aclk);
            if (pwm_pins.level[0] === 1'b1) h++;
            if (pwm_pins.level[3:1] !== 3'h0) hd++;
        end
    endtask : measure
endmodule : arp_pin_model

// >>> testbench/testbench.sv
// Purpose: Self-checking bench of the auto-reload PWM timer over AXI4-Lite
// Assumes: Counter runs at aclk rate (divide 1) during PWM checks
// Notes:   Handshakes seen at the falling edge, acted on at the next rising edge
`timescale 1ns/1ps
`include "arp_regs.svh"
module testbench;
    import arp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, ext_clk;
    logic [1:0] bresp, rresp, cap_pins;
    logic [31:0] rdata, d;
    logic [1:0] r;
    arp_pwm_pins_t pwm_pins;
    int n_fail = 0, checked = 0, cyc = 0, h, hd;

    always #4 aclk = ~aclk;

    arp_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clk_pin(ext_clk),
        .cap_pins(cap_pins), .pwm_pins(pwm_pins), .irq(irq));
    arp_pin_model model (.aclk(aclk), .pwm_pins(pwm_pins), .cap_pins(cap_pins), .ext_clk_pin(ext_clk));

    // ----------------------------------------------------------------
    // Bus tasks and compare
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Upper lanes carry junk on purpose: the block must ignore them
    task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] rs);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'ha5a5a5, v};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] dv, output logic [1:0] rs);
        logic ta, tv;
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = arvalid && arready;
            tv = rvalid && rready;
            dv = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tv) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    task automatic wok(input logic [7:0] idx, input logic [7:0] v);
        logic [1:0] rs;
        wr(idx, v, rs);
        chk("write resp", {30'h0, `ARP_RESP_OKAY}, {30'h0, rs});
    endtask : wok

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
        logic [31:0] dv;
        logic [1:0] rs;
        rd(idx, dv, rs);
        chk(nm, {24'h0, e}, dv);
        chk("read resp", {30'h0, `ARP_RESP_OKAY}, {30'h0, rs});
    endtask : rchk

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // Whole run needs well under two thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 8'h73; i <= 8'h7d; i++) rchk(i[7:0], 8'h00, "reset value");
        rd(8'h90, d, r);
        chk("unmapped resp", {30'h0, `ARP_RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        for (int i = 0; i < 4; i++) wok(8'h73 + i[7:0], 8'h11 * (i[7:0] + 8'h1));
        for (int i = 0; i < 4; i++) rchk(8'h73 + i[7:0], 8'h11 * (i[7:0] + 8'h1), "duty");
        wok(`ARP_IDX_ICCSR, 8'hff);
        rchk(`ARP_IDX_ICCSR, 8'h3c, "capture control");
        wok(`ARP_IDX_ICCSR, 8'h00);
        // PWM with reload 0: every count once per 256 cycles
        wok(`ARP_IDX_DUTY0, 8'h80);
        wok(`ARP_IDX_ARR, 8'h00);
        wok(`ARP_IDX_PWM_ENABLE_POLARITY, 8'h10);
        wok(`ARP_IDX_CSR, 8'h0c);
        chk("output enable", 32'h1, {28'h0, pwm_pins.oe});
        model.measure(256, h, hd);
        chk("ch0 high count", 129, h);
        chk("disabled levels", 0, hd);
        wok(`ARP_IDX_PWM_ENABLE_POLARITY, 8'h11);
        model.measure(256, h, hd);
        chk("inverted high count", 127, h);
        wok(`ARP_IDX_DUTY0, 8'he0);
        wok(`ARP_IDX_ARR, 8'hc0);
        wok(`ARP_IDX_PWM_ENABLE_POLARITY, 8'h10);
        repeat (300) @(posedge aclk);
        model.measure(256, h, hd);
        chk("reload high count", 132, h);
        wok(`ARP_IDX_CSR, 8'h00);
        rchk(`ARP_IDX_CSR, 8'h01, "overflow flag set");
        rchk(`ARP_IDX_CSR, 8'h00, "overflow flag cleared");
        chk("irq masked", 32'h0, {31'h0, irq});
        wok(`ARP_IDX_IRQ_ENABLE, 8'h01);
        chk("irq enabled", 32'h1, {31'h0, irq});
        wok(`ARP_IDX_IRQ_CLEAR, 8'h01);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // External count clock, divide by 2, started by a forced reload
        wok(`ARP_IDX_CSR, 8'h9c);
        model.pulse_ext(6);
        wok(`ARP_IDX_CSR, 8'h00);
        rchk(`ARP_IDX_CAR, 8'hc3, "external count");
        // Polarity flip and captures with the counter frozen at known values
        wok(`ARP_IDX_CAR, 8'h5a);
        @(negedge aclk);
        chk("level before flip", 32'h1, {31'h0, pwm_pins.level[0]});
        wok(`ARP_IDX_PWM_ENABLE_POLARITY, 8'h11);
        @(negedge aclk);
        chk("level after flip", 32'h0, {31'h0, pwm_pins.level[0]});
        wok(`ARP_IDX_ICCSR, 8'h14);
        model.set_cap(0, 1'b1);
        repeat (8) @(posedge aclk);
        rchk(`ARP_IDX_ICCSR, 8'h15, "flag ch1");
        chk("capture irq", 32'h1, {31'h0, irq});
        wok(`ARP_IDX_CAR, 8'h33);
        model.set_cap(1, 1'b1);
        repeat (8) @(posedge aclk);
        rchk(`ARP_IDX_ICCSR, 8'h15, "rise ignored ch2");
        model.set_cap(1, 1'b0);
        repeat (8) @(posedge aclk);
        rchk(`ARP_IDX_ICCSR, 8'h17, "flag ch2");
        rchk(`ARP_IDX_ICR1, 8'h5a, "capture ch1");
        rchk(`ARP_IDX_ICCSR, 8'h16, "flag ch1 cleared");
        chk("irq disabled ch2", 32'h0, {31'h0, irq});
        wr(`ARP_IDX_ICR1, 8'hff, r);
        rchk(`ARP_IDX_ICR1, 8'h5a, "capture read only");
        rchk(`ARP_IDX_ICR2, 8'h33, "capture ch2");
        rchk(`ARP_IDX_ICCSR, 8'h14, "flag ch2 cleared");
        rchk(`ARP_IDX_IRQ_STATUS, 8'h06, "sticky status");
        finish_test();
    end
endmodule : testbench
